// File: pkg/rpc_pkg.sv
/*
 * rpc_pkg: constants, types and register map for the rtc power and misc control block.
 * assumes a 125 MHz system clock; register offsets are byte addresses on axi4-lite.
 */
package rpc_pkg;
  localparam int unsigned CLK_HZ = 125000000;
  // recovery deselect times: the minimum of each range
  localparam int unsigned REC_SLOW_MIN_MS = 96;
  localparam int unsigned REC_HALT_MIN_MS = 40;
  localparam int unsigned REC_FAST_MIN_US = 50;
  localparam int unsigned REC_SLOW_CYC = REC_SLOW_MIN_MS * (CLK_HZ / 1000);
  localparam int unsigned REC_HALT_CYC = REC_HALT_MIN_MS * (CLK_HZ / 1000);
  localparam int unsigned REC_FAST_CYC = REC_FAST_MIN_US * (CLK_HZ / 1000000);
  localparam int unsigned BAT_CHECK_HOURS = 24;
  localparam longint unsigned BAT_CHECK_CYC = 64'(BAT_CHECK_HOURS) * 3600 * CLK_HZ;
  localparam int CNT_W = 48;

  // register byte addresses (index times four)
  localparam logic [7:0] ADDR_CENTURY = 8'h0c; // index 03h
  localparam logic [7:0] ADDR_CLOCK4 = 8'h10;  // index 04h
  localparam logic [7:0] ADDR_CTRL = 8'h20;    // index 08h
  localparam logic [7:0] ADDR_WDOG = 8'h24;    // index 09h
  localparam logic [7:0] ADDR_ALARM = 8'h28;   // index 0ah
  localparam logic [7:0] ADDR_FLAGS = 8'h3c;   // index 0fh
  localparam logic [7:0] ADDR_STAT = 8'h40;
  localparam logic [7:0] ADDR_MASK = 8'h44;
  localparam logic [7:0] ADDR_CMD = 8'h48;

  // bit positions
  localparam int B_CENT_EN = 7;
  localparam int B_CENT_FLAG = 6;
  localparam int B_REC_SEL = 7;
  localparam int B_OSC_HALT = 7;
  localparam int B_PIN_LEVEL = 7;
  localparam int B_FREQ_TEST = 6;
  localparam int B_ALARM_FE = 7;
  localparam int B_ALARM_BE = 5;
  localparam int B_SQW_EN = 6;
  localparam int B_HALT_UPD = 6;
  localparam int B_BAT_LOW = 4;
  localparam int B_CMD_ROLL = 0;
  localparam int B_CMD_HALT = 1;

  // status event bits
  localparam int EV_PFAIL = 0;
  localparam int EV_BATLOW = 1;
  localparam int EV_RECDONE = 2;
  localparam int EV_CENTURY = 3;
  localparam int EV_W = 4;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic recovery_time_select;
    logic oscillator_halt_bit;
    logic halt_update_flag;
    logic pin_level;
    logic frequency_test_enable;
    logic alarm_flag_enable;
    logic alarm_backup_enable;
    logic square_wave_enable;
    logic [7:0] watchdog;
    logic century_toggle_enable;
    logic century_flag;
  } rpc_ctrl_type;

  typedef enum logic [3:0] {
    PWR_BACKUP = 4'b0001,
    PWR_RECOVER = 4'b0010,
    PWR_NORMAL = 4'b0100,
    PWR_INIT = 4'b1000
  } rpc_pwr_type;
endpackage : rpc_pkg

// File: src/rpc_power_ctrl.sv
/*
 * rpc_power_ctrl: power-fail output, recovery deselect, power-up defaults,
 * century toggle, multifunction open-drain pin and battery-low checks,
 * with registers on an axi4-lite slave.
 * assumes comparator, supply detect and battery compare come from the analog side
 * asynchronously; power-up is first seen after reset release.
 */
// Local design decisions: the register addresses and the AXI4-Lite slave port.
// Function
// - power-fail output low when sense below threshold
// - in back-up, comparator off, output held low
// - on return, output forced high for recovery
// - century flag toggles at rollover only when enabled
// - idle pin follows pin level bit
// - multifunction pin is open drain, pulls low only
// - battery check at power-up and daily
// - battery low flag set when check fails
// - battery low flag stays until check passes
// - no battery checks during back-up
// - recovery select is bit 7 of 04h
// - recovery time chosen from select and halt
// - bus writes deselected during recovery time; mask register writes still apply while deselected
// - first power-up loads listed defaults
// - later power-up clears enables, sets halt update
// - watchdog register fully cleared at power-up
`timescale 1ns/1ns
module rpc_power_ctrl #(
  parameter longint unsigned BAT_CHECK_CYCLES = rpc_pkg::BAT_CHECK_CYC,
  parameter int unsigned REC_SLOW_CYCLES = rpc_pkg::REC_SLOW_CYC,
  parameter int unsigned REC_HALT_CYCLES = rpc_pkg::REC_HALT_CYC,
  parameter int unsigned REC_FAST_CYCLES = rpc_pkg::REC_FAST_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic sense_below_i,
  input wire logic supply_ok_i,
  input wire logic battery_below_i,
  input wire logic battery_attached_i,
  input wire logic century_rollover_i,
  output logic power_fail_flag_out_o,
  output logic multifunction_irq_pin_o,
  output logic multifunction_irq_pin_oe_o,
  output logic deselect_o,
  output logic irq_o
);
  logic sense_m, sense_s, supply_m, supply_s, bat_m, bat_s, roll_m, roll_s, roll_d;
  logic battery_attached_seen;
  rpc_pkg::rpc_ctrl_type ctrl;
  rpc_pkg::rpc_pwr_type pwr_state;
  logic [rpc_pkg::CNT_W-1:0] rec_cnt, bat_cnt;
  logic battery_low_flag;
  logic [rpc_pkg::EV_W-1:0] stat, mask, ev;
  logic aw_hold, w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire, rd_fire, first_power, bat_check, rec_done, roll_evt;
  logic [31:0] next_rdata;
  logic next_rd_ok;

  function automatic logic [rpc_pkg::CNT_W-1:0] rec_len(input logic sel, input logic halt);
    if (sel) begin
      rec_len = rpc_pkg::CNT_W'(REC_FAST_CYCLES);
    end else if (halt) begin
      rec_len = rpc_pkg::CNT_W'(REC_HALT_CYCLES);
    end else begin
      rec_len = rpc_pkg::CNT_W'(REC_SLOW_CYCLES);
    end
  endfunction : rec_len

  // two-stage synchronisers
  // rollover keeps a third stage so its edge detector reads only settled values
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {sense_m, sense_s, supply_m, supply_s} <= 4'h0;
      {bat_m, bat_s, roll_m, roll_s, roll_d} <= 5'h00;
    end else begin
      sense_m <= sense_below_i;
      sense_s <= sense_m;
      supply_m <= supply_ok_i;
      supply_s <= supply_m;
      bat_m <= battery_below_i;
      bat_s <= bat_m;
      roll_m <= century_rollover_i;
      roll_s <= roll_m;
      roll_d <= roll_s;
    end
  end
  assign roll_evt = roll_s & ~roll_d;

  // power state: back-up, recovery, normal
  // a supply drop during recovery returns to back-up; the next return restarts the count
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pwr_state <= rpc_pkg::PWR_INIT;
      rec_cnt <= '0;
    end else begin
      case (pwr_state)
        rpc_pkg::PWR_INIT: begin
          pwr_state <= rpc_pkg::PWR_BACKUP;
        end
        rpc_pkg::PWR_BACKUP: begin
          if (supply_s) begin
            pwr_state <= rpc_pkg::PWR_RECOVER;
            rec_cnt <= rec_len(ctrl.recovery_time_select, ctrl.oscillator_halt_bit);
          end
        end
        rpc_pkg::PWR_RECOVER: begin
          if (!supply_s) begin
            pwr_state <= rpc_pkg::PWR_BACKUP;
          end else if (rec_cnt <= rpc_pkg::CNT_W'(1)) begin
            pwr_state <= rpc_pkg::PWR_NORMAL;
          end else begin
            rec_cnt <= rec_cnt - rpc_pkg::CNT_W'(1);
          end
        end
        rpc_pkg::PWR_NORMAL: begin
          if (!supply_s) begin
            pwr_state <= rpc_pkg::PWR_BACKUP;
          end
        end
        default: pwr_state <= rpc_pkg::PWR_BACKUP;
      endcase
    end
  end
  // last recovery cycle: defaults load and the power-up battery check runs here
  assign rec_done = (pwr_state == rpc_pkg::PWR_RECOVER) && supply_s &&
                    (rec_cnt <= rpc_pkg::CNT_W'(1));
  assign deselect_o = (pwr_state != rpc_pkg::PWR_NORMAL);

  // power-fail output
  // follows the synchronised comparator with one register of delay in normal
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      power_fail_flag_out_o <= 1'b0;
    end else begin
      case (pwr_state)
        rpc_pkg::PWR_RECOVER: power_fail_flag_out_o <= 1'b1;
        rpc_pkg::PWR_NORMAL: power_fail_flag_out_o <= ~sense_s;
        default: power_fail_flag_out_o <= 1'b0;
      endcase
    end
  end

  // first power-up is when the battery is newly attached
  // sampled in the single init cycle, so only a reset can make it first power again
  assign first_power = ~battery_attached_seen;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      battery_attached_seen <= 1'b0;
    end else if (pwr_state == rpc_pkg::PWR_INIT) begin
      battery_attached_seen <= battery_attached_i;
    end else if (rec_done) begin
      battery_attached_seen <= 1'b1;
    end
  end

  assign wr_fire = aw_hold && w_hold && !s_axi_bvalid;

  // control bits, power-up defaults, century toggle, host writes
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl <= '0;
    end else begin
      if (rec_done) begin
        if (first_power) begin
          ctrl.recovery_time_select <= 1'b0;
          ctrl.oscillator_halt_bit <= 1'b1;
          ctrl.pin_level <= 1'b1;
        end
        ctrl.halt_update_flag <= 1'b1;
        ctrl.frequency_test_enable <= 1'b0;
        ctrl.alarm_flag_enable <= 1'b0;
        ctrl.alarm_backup_enable <= 1'b0;
        ctrl.square_wave_enable <= 1'b0;
        ctrl.watchdog <= 8'h00;
      end
      // rollover may land in the last recovery cycle, so it is not gated by rec_done
      if (roll_evt && ctrl.century_toggle_enable) begin
        ctrl.century_flag <= ~ctrl.century_flag;
      end
      // control writes during deselect are dropped but still answered okay
      if (wr_fire && !deselect_o && w_strb[0]) begin
        case (aw_addr)
          rpc_pkg::ADDR_CENTURY: begin
            ctrl.century_toggle_enable <= w_data[rpc_pkg::B_CENT_EN];
            ctrl.century_flag <= w_data[rpc_pkg::B_CENT_FLAG];
          end
          rpc_pkg::ADDR_CLOCK4: ctrl.recovery_time_select <= w_data[rpc_pkg::B_REC_SEL];
          rpc_pkg::ADDR_CTRL: begin
            ctrl.pin_level <= w_data[rpc_pkg::B_PIN_LEVEL];
            ctrl.frequency_test_enable <= w_data[rpc_pkg::B_FREQ_TEST];
          end
          rpc_pkg::ADDR_WDOG: ctrl.watchdog <= w_data[7:0];
          rpc_pkg::ADDR_ALARM: begin
            ctrl.alarm_flag_enable <= w_data[rpc_pkg::B_ALARM_FE];
            ctrl.square_wave_enable <= w_data[rpc_pkg::B_SQW_EN];
            ctrl.alarm_backup_enable <= w_data[rpc_pkg::B_ALARM_BE];
          end
          rpc_pkg::ADDR_FLAGS: ctrl.halt_update_flag <= w_data[rpc_pkg::B_HALT_UPD];
          rpc_pkg::ADDR_CMD: ctrl.oscillator_halt_bit <= w_data[rpc_pkg::B_CMD_HALT];
          default: ;
        endcase
      end
    end
  end

  // multifunction pin: open drain, driven only when pulling low
  assign multifunction_irq_pin_o = 1'b0;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      multifunction_irq_pin_oe_o <= 1'b0;
    end else begin
      multifunction_irq_pin_oe_o <= !ctrl.frequency_test_enable && !ctrl.alarm_flag_enable &&
                                    (ctrl.watchdog == 8'h00) && !ctrl.pin_level;
    end
  end

  // battery checks: at power-up and on a daily interval while powered
  // the interval count is held at zero outside normal, so back-up never checks
  assign bat_check = rec_done || ((pwr_state == rpc_pkg::PWR_NORMAL) &&
                     (bat_cnt >= rpc_pkg::CNT_W'(BAT_CHECK_CYCLES - 1)));
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bat_cnt <= '0;
      battery_low_flag <= 1'b0;
    end else begin
      if (pwr_state != rpc_pkg::PWR_NORMAL || bat_check) begin
        bat_cnt <= '0;
      end else begin
        bat_cnt <= bat_cnt + rpc_pkg::CNT_W'(1);
      end
      if (bat_check) begin
        battery_low_flag <= bat_s;
      end
    end
  end

  // interrupt status: sticky, cleared by a read, set wins
  assign ev = {roll_evt, rec_done, bat_check & bat_s,
               (pwr_state == rpc_pkg::PWR_NORMAL) & sense_s & power_fail_flag_out_o};
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stat <= '0;
      mask <= '0;
    end else begin
      if (rd_fire && s_axi_araddr == rpc_pkg::ADDR_STAT) begin
        stat <= ev;
      end else begin
        stat <= stat | ev;
      end
      // mask writes apply even while deselected
      if (wr_fire && w_strb[0] && aw_addr == rpc_pkg::ADDR_MASK) begin
        mask <= w_data[rpc_pkg::EV_W-1:0];
      end
    end
  end
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_o <= 1'b0;
    end else begin
      // registered so the level cannot glitch while status and mask change together
      irq_o <= |(stat & mask);
    end
  end

  // axi4-lite write path
  // each ready falls once its channel is held; the response waits for both halves
  assign s_axi_awready = !aw_hold;
  assign s_axi_wready = !w_hold;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rpc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok(aw_addr) ? rpc_pkg::RESP_OKAY : rpc_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // status is read-only: a write there answers with slverr
  function automatic logic wr_ok(input logic [7:0] a);
    case (a)
      rpc_pkg::ADDR_CENTURY, rpc_pkg::ADDR_CLOCK4, rpc_pkg::ADDR_CTRL, rpc_pkg::ADDR_WDOG,
      rpc_pkg::ADDR_ALARM, rpc_pkg::ADDR_FLAGS, rpc_pkg::ADDR_MASK,
      rpc_pkg::ADDR_CMD: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  endfunction : wr_ok

  // axi4-lite read path
  // read data is captured at the address handshake and held until rready
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  always_comb begin
    next_rdata = 32'h0;
    next_rd_ok = 1'b1;
    case (s_axi_araddr)
      rpc_pkg::ADDR_CENTURY: begin
        next_rdata[rpc_pkg::B_CENT_EN] = ctrl.century_toggle_enable;
        next_rdata[rpc_pkg::B_CENT_FLAG] = ctrl.century_flag;
      end
      rpc_pkg::ADDR_CLOCK4: next_rdata[rpc_pkg::B_REC_SEL] = ctrl.recovery_time_select;
      rpc_pkg::ADDR_CTRL: begin
        next_rdata[rpc_pkg::B_PIN_LEVEL] = ctrl.pin_level;
        next_rdata[rpc_pkg::B_FREQ_TEST] = ctrl.frequency_test_enable;
      end
      rpc_pkg::ADDR_WDOG: next_rdata[7:0] = ctrl.watchdog;
      rpc_pkg::ADDR_ALARM: begin
        next_rdata[rpc_pkg::B_ALARM_FE] = ctrl.alarm_flag_enable;
        next_rdata[rpc_pkg::B_SQW_EN] = ctrl.square_wave_enable;
        next_rdata[rpc_pkg::B_ALARM_BE] = ctrl.alarm_backup_enable;
      end
      rpc_pkg::ADDR_FLAGS: begin
        next_rdata[rpc_pkg::B_HALT_UPD] = ctrl.halt_update_flag;
        next_rdata[rpc_pkg::B_BAT_LOW] = battery_low_flag;
      end
      rpc_pkg::ADDR_STAT: next_rdata[rpc_pkg::EV_W-1:0] = stat;
      rpc_pkg::ADDR_MASK: next_rdata[rpc_pkg::EV_W-1:0] = mask;
      rpc_pkg::ADDR_CMD: begin
        next_rdata[rpc_pkg::B_CMD_HALT] = ctrl.oscillator_halt_bit;
        next_rdata[rpc_pkg::B_CMD_ROLL] = deselect_o;
      end
      default: next_rd_ok = 1'b0;
    endcase
  end
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= rpc_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rd_ok ? rpc_pkg::RESP_OKAY : rpc_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : rpc_power_ctrl

// File: sim/rpc_power_ctrl_sva.sv
/* rpc_chk: port-level checks of the power control block.
   assumes one clock domain and the active-low asynchronous reset of the block. */
`timescale 1ns/1ns
module rpc_chk (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic sense_below_i,
  input wire logic supply_ok_i,
  input wire logic power_fail_flag_out_o,
  input wire logic multifunction_irq_pin_o,
  input wire logic deselect_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence supply_gone;
    !supply_ok_i [*5];
  endsequence
  sequence supply_back;
    (supply_ok_i && deselect_o) [*6];
  endsequence
  pfo_backup_low_a: assert property (supply_gone |-> !power_fail_flag_out_o)
    else $error("power fail output high in back-up");
  desel_backup_a: assert property (supply_gone |-> deselect_o)
    else $error("bus not deselected in back-up");
  pfo_recov_high_a: assert property (supply_back |-> power_fail_flag_out_o)
    else $error("power fail output not forced high in recovery");
  pfo_sense_low_a: assert property ((sense_below_i && !deselect_o) [*5]
    |-> !power_fail_flag_out_o)
    else $error("power fail output ignores sense");
  sense_sync_a: assert property ($rose(sense_below_i) && power_fail_flag_out_o && !deselect_o
    |=> power_fail_flag_out_o)
    else $error("sense reached output without synchroniser delay");
  pin_drain_a: assert property (multifunction_irq_pin_o == 1'b0)
    else $error("multifunction pin driven high");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule : rpc_chk
bind rpc_power_ctrl rpc_chk rpc_chk_inst (.sys_clk_i, .rstn_i, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready, .sense_below_i, .supply_ok_i,
  .power_fail_flag_out_o, .multifunction_irq_pin_o, .deselect_o);

// File: sim/rpc_host_model.sv
/* rpc_host_model: axi4-lite master standing in for the host processor.
   assumes tasks are entered just after a rising clock edge. */
`timescale 1ns/1ns
module rpc_host_model (
  input wire logic sys_clk_i,
  output logic awvalid_o,
  output logic [7:0] awaddr_o,
  input wire logic awready_i,
  output logic wvalid_o,
  output logic [31:0] wdata_o,
  output logic [3:0] wstrb_o,
  input wire logic wready_i,
  input wire logic bvalid_i,
  output logic bready_o,
  output logic arvalid_o,
  output logic [7:0] araddr_o,
  input wire logic arready_i,
  input wire logic rvalid_i,
  output logic rready_o,
  input wire logic [31:0] rdata_i
);
  initial begin
    {awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o} = 5'h00;
    {awaddr_o, araddr_o, wdata_o, wstrb_o} = 52'h0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr_o <= a;
    wdata_o <= d;
    wstrb_o <= 4'hf;
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (awvalid_o && awready_i) awvalid_o <= 1'b0;
      if (wvalid_o && wready_i) wvalid_o <= 1'b0;
    end while ((awvalid_o && !awready_i) || (wvalid_o && !wready_i));
    do @(posedge sys_clk_i); while (bvalid_i !== 1'b1);
    bready_o <= 1'b0;
    // one edge passes so a following call never re-raises bready in this time step
    @(posedge sys_clk_i);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    do @(posedge sys_clk_i); while (arready_i !== 1'b1);
    arvalid_o <= 1'b0;
    do @(posedge sys_clk_i); while (rvalid_i !== 1'b1);
    d = rdata_i;
    rready_o <= 1'b0;
    @(posedge sys_clk_i);
  endtask : rd
endmodule : rpc_host_model

// File: sim/rpc_power_ctrl_bench.sv
/* rpc_power_ctrl_bench: self-checking bench of the power control block.
   assumes shortened recovery and battery counts set at the instance. */
`timescale 1ns/1ns
module rpc_power_ctrl_bench;
  logic sys_clk_i, rstn_i, sense_below_i, supply_ok_i, battery_below_i, attached, rollover;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic power_fail_flag_out, pin, pin_oe, desel, irq;
  int n_mismatch, cmp_count, cyc;
  rpc_power_ctrl #(.BAT_CHECK_CYCLES(200), .REC_SLOW_CYCLES(20), .REC_HALT_CYCLES(10),
    .REC_FAST_CYCLES(5)) rpc_power_ctrl_inst (.sys_clk_i, .rstn_i, .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .sense_below_i,
    .supply_ok_i, .battery_below_i, .battery_attached_i(attached), .century_rollover_i(rollover),
    .power_fail_flag_out_o(power_fail_flag_out), .multifunction_irq_pin_o(pin),
    .multifunction_irq_pin_oe_o(pin_oe), .deselect_o(desel), .irq_o(irq));
  rpc_host_model rpc_host_model_inst (.sys_clk_i, .awvalid_o(awvalid), .awaddr_o(awaddr),
    .awready_i(awready), .wvalid_o(wvalid), .wdata_o(wdata), .wstrb_o(wstrb),
    .wready_i(wready), .bvalid_i(bvalid), .bready_o(bready), .arvalid_o(arvalid),
    .araddr_o(araddr), .arready_i(arready), .rvalid_i(rvalid), .rready_o(rready),
    .rdata_i(rdata));
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : wt
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    rpc_host_model_inst.wr(a, d);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    rpc_host_model_inst.rd(a, rv);
    check($sformatf("reg %h", a), rv, exp);
    check($sformatf("resp %h", a), rresp, rpc_pkg::RESP_OKAY);
  endtask : rdchk
  task automatic roll();
    rollover <= 1'b1;
    wt(4);
    rollover <= 1'b0;
    wt(4);
  endtask : roll
  task automatic t_first_power();
    while (desel !== 1'b0) @(posedge sys_clk_i);
    rdchk(rpc_pkg::ADDR_CLOCK4, 32'h0);
    rdchk(rpc_pkg::ADDR_CMD, 32'h2);
    rdchk(rpc_pkg::ADDR_CTRL, 32'h80);
    rdchk(rpc_pkg::ADDR_WDOG, 32'h0);
    rdchk(rpc_pkg::ADDR_ALARM, 32'h0);
    rdchk(rpc_pkg::ADDR_FLAGS, 32'h50);
    check("pfo", power_fail_flag_out, 1'b1);
    check("pin oe", pin_oe, 1'b0);
  endtask : t_first_power
  task automatic t_pin();
    battery_below_i <= 1'b0;
    wr(rpc_pkg::ADDR_CTRL, 32'h0);
    check("wr resp", bresp, rpc_pkg::RESP_OKAY);
    wt(3);
    check("pin oe", pin_oe, 1'b1);
    check("pin", pin, 1'b0);
    wr(rpc_pkg::ADDR_CTRL, 32'h40);
    wt(3);
    check("pin oe", pin_oe, 1'b0);
    wr(rpc_pkg::ADDR_CTRL, 32'h0);
    wr(rpc_pkg::ADDR_WDOG, 32'h01);
    wt(3);
    check("pin oe", pin_oe, 1'b0);
    wr(rpc_pkg::ADDR_WDOG, 32'h0);
    wr(rpc_pkg::ADDR_ALARM, 32'h80);
    wt(3);
    check("pin oe", pin_oe, 1'b0);
    wr(rpc_pkg::ADDR_ALARM, 32'h0);
    wt(3);
    check("pin oe", pin_oe, 1'b1);
  endtask : t_pin
  task automatic t_century();
    wr(rpc_pkg::ADDR_CENTURY, 32'h80);
    roll();
    rdchk(rpc_pkg::ADDR_CENTURY, 32'hc0);
    roll();
    rdchk(rpc_pkg::ADDR_CENTURY, 32'h80);
    wr(rpc_pkg::ADDR_CENTURY, 32'h40);
    roll();
    rdchk(rpc_pkg::ADDR_CENTURY, 32'h40);
    wr(rpc_pkg::ADDR_CENTURY, 32'h0);
  endtask : t_century
  task automatic t_irq();
    rpc_host_model_inst.rd(rpc_pkg::ADDR_STAT, rv);
    wr(rpc_pkg::ADDR_MASK, 32'h8);
    roll();
    check("irq", irq, 1'b1);
    rdchk(rpc_pkg::ADDR_STAT, 32'h8);
    wt(2);
    check("irq", irq, 1'b0);
    wr(rpc_pkg::ADDR_MASK, 32'h0);
    roll();
    check("irq", irq, 1'b0);
    rdchk(rpc_pkg::ADDR_STAT, 32'h8);
    rpc_host_model_inst.rd(8'h80, rv);
    check("unmapped data", rv, 32'h0);
    check("unmapped resp", rresp, rpc_pkg::RESP_SLVERR);
    wr(8'h80, 32'h0);
    check("unmapped wr resp", bresp, rpc_pkg::RESP_SLVERR);
  endtask : t_irq
  task automatic t_battery_sense();
    battery_below_i <= 1'b0;
    wt(250);
    rdchk(rpc_pkg::ADDR_FLAGS, 32'h40);
    battery_below_i <= 1'b1;
    wt(250);
    rdchk(rpc_pkg::ADDR_FLAGS, 32'h50);
    battery_below_i <= 1'b0;
    wt(250);
    rdchk(rpc_pkg::ADDR_FLAGS, 32'h40);
    sense_below_i <= 1'b1;
    wt(6);
    check("pfo", power_fail_flag_out, 1'b0);
    sense_below_i <= 1'b0;
    wt(6);
    check("pfo", power_fail_flag_out, 1'b1);
  endtask : t_battery_sense
  task automatic power_cycle(input int exp);
    int n;
    n = 0;
    supply_ok_i <= 1'b0;
    battery_below_i <= 1'b1;
    wt(6);
    wr(rpc_pkg::ADDR_CENTURY, 32'hc0);
    check("deselected wr resp", bresp, rpc_pkg::RESP_OKAY);
    wt(300);
    check("pfo", power_fail_flag_out, 1'b0);
    check("deselect", desel, 1'b1);
    battery_below_i <= 1'b0;
    supply_ok_i <= 1'b1;
    while (power_fail_flag_out !== 1'b1) @(posedge sys_clk_i);
    while (desel === 1'b1) begin
      n++;
      @(posedge sys_clk_i);
    end
    check("recovery length", n >= exp - 2 && n <= exp + 1, 1'b1);
    rdchk(rpc_pkg::ADDR_FLAGS, 32'h40);
    rdchk(rpc_pkg::ADDR_CENTURY, 32'h0);
  endtask : power_cycle
  task automatic t_later_power();
    wr(rpc_pkg::ADDR_CLOCK4, 32'h80);
    wr(rpc_pkg::ADDR_CTRL, 32'h40);
    wr(rpc_pkg::ADDR_ALARM, 32'he0);
    wr(rpc_pkg::ADDR_WDOG, 32'h55);
    wr(rpc_pkg::ADDR_FLAGS, 32'h0);
    power_cycle(5);
    rdchk(rpc_pkg::ADDR_CLOCK4, 32'h80);
    rdchk(rpc_pkg::ADDR_CTRL, 32'h0);
    rdchk(rpc_pkg::ADDR_ALARM, 32'h0);
    rdchk(rpc_pkg::ADDR_WDOG, 32'h0);
    wr(rpc_pkg::ADDR_CLOCK4, 32'h0);
    power_cycle(10);
    rdchk(rpc_pkg::ADDR_CMD, 32'h2);
    wr(rpc_pkg::ADDR_CMD, 32'h0);
    power_cycle(20);
  endtask : t_later_power
  task automatic t_reset_attached();
    rstn_i <= 1'b0;
    attached <= 1'b1;
    wt(4);
    check("deselect in reset", desel, 1'b1);
    check("pfo in reset", power_fail_flag_out, 1'b0);
    rstn_i <= 1'b1;
    while (desel !== 1'b0) @(posedge sys_clk_i);
    rdchk(rpc_pkg::ADDR_CMD, 32'h0);
    rdchk(rpc_pkg::ADDR_CTRL, 32'h0);
    rdchk(rpc_pkg::ADDR_FLAGS, 32'h40);
  endtask : t_reset_attached
  initial begin
    {rstn_i, sense_below_i, attached, rollover, cyc, n_mismatch, cmp_count} = '0;
    supply_ok_i = 1'b1;
    battery_below_i = 1'b1;
    wt(4);
    rstn_i <= 1'b1;
    t_first_power();
    t_pin();
    t_century();
    t_irq();
    t_battery_sense();
    t_later_power();
    t_reset_attached();
    stop_test();
  end
endmodule : rpc_power_ctrl_bench
